// ---- cap_pkg.sv ----
// Package with addresses, field positions, types and counts of the counter array.
package cap_pkg;

   // Register addresses on the special function register port.
   localparam logic [7:0] CAP_ADDR_CTRL    = 8'hD8;
   localparam logic [7:0] CAP_ADDR_MODE    = 8'hD9;
   localparam logic [7:0] CAP_ADDR_MMODE0  = 8'hDA;
   localparam logic [7:0] CAP_ADDR_CNT_LO  = 8'hF9;
   localparam logic [7:0] CAP_ADDR_CNT_HI  = 8'hFA;
   localparam logic [7:0] CAP_ADDR_CPL [6] = '{8'hFB, 8'hFD, 8'hE9,
                                               8'hEB, 8'hED, 8'hE1};
   localparam logic [7:0] CAP_ADDR_CPH [6] = '{8'hFC, 8'hFE, 8'hEA,
                                               8'hEC, 8'hEE, 8'hE2};

   // Number of capture/compare modules.
   localparam int CAP_NMOD = 6;

   // Control register fields.
   localparam int CAP_CTRL_OVF = 7;
   localparam int CAP_CTRL_RUN = 6;

   // Mode register fields.
   localparam int         CAP_MODE_IDLE  = 7;
   localparam int         CAP_MODE_TB_HI = 3;
   localparam int         CAP_MODE_TB_LO = 1;
   localparam int         CAP_MODE_OVFIE = 0;
   localparam logic [7:0] CAP_MODE_MASK  = 8'h8F;

   // Module mode register fields.
   localparam int CAP_MM_WIDE = 7;
   localparam int CAP_MM_ECOM = 6;
   localparam int CAP_MM_CAPP = 5;
   localparam int CAP_MM_CAPN = 4;
   localparam int CAP_MM_MAT  = 3;
   localparam int CAP_MM_TOG  = 2;
   localparam int CAP_MM_PWM  = 1;
   localparam int CAP_MM_IRQE = 0;

   // Reset values.
   localparam logic [7:0]  CAP_RST_BYTE = 8'h00;
   localparam logic [15:0] CAP_RST_CNT  = 16'h0000;

   // Timebase select codes.
   localparam logic [2:0] CAP_TB_DIV12 = 3'h0;
   localparam logic [2:0] CAP_TB_DIV4  = 3'h1;
   localparam logic [2:0] CAP_TB_T0OVF = 3'h2;
   localparam logic [2:0] CAP_TB_EXTIN = 3'h3;
   localparam logic [2:0] CAP_TB_SYS   = 3'h4;
   localparam logic [2:0] CAP_TB_OSC8  = 3'h5;

   // Divider terminal counts.
   localparam logic [3:0] CAP_DIV12_LAST = 4'hB;
   localparam logic [1:0] CAP_DIV4_LAST  = 2'h3;
   localparam logic [2:0] CAP_OSC8_LAST  = 3'h7;

   // Least high or low time of the external count input, in clocks.
   localparam int CAP_EXTIN_MIN_CYC = 2;

   // Counter wrap values.
   localparam logic [15:0] CAP_CNT_TOP = 16'hFFFF;
   localparam logic [7:0]  CAP_LO_ZERO = 8'h00;

   // Register bus request carried as one bundle.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cap_sfr_req_t;

   // Module operating modes, Gray coded along the usual path.
   typedef enum logic [2:0] {
      CAP_OP_OFF   = 3'b000,
      CAP_OP_SWT   = 3'b001,
      CAP_OP_HSO   = 3'b011,
      CAP_OP_FREQ  = 3'b010,
      CAP_OP_PWM8  = 3'b110,
      CAP_OP_PWM16 = 3'b111
   } cap_op_t;

endpackage

// ---- cap_counter_array.sv ----
// Counter array with compare, toggle, frequency and pulse width outputs.
`timescale 1ns/1ps
module cap_counter_array
   import cap_pkg::*;
(
   // Clock and reset.
   input  wire logic         ref_clk,
   input  wire logic         reset,
   // Register port.
   input  wire cap_sfr_req_t sfr_req,
   output logic [7:0]        sfr_rdata,
   // System inputs.
   input  wire logic         cpu_idle,
   input  wire logic         timer0_ovf,
   input  wire logic         external_count_input,
   input  wire logic         ext_osc_in,
   // Outputs.
   output logic [5:0]        module_io_pin,
   output logic              irq_req
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers.

   // Picks the operating mode from a module mode byte.
   function automatic cap_op_t op_of(input logic [7:0] mm);
      cap_op_t op;
      op = CAP_OP_OFF;
      if (mm[CAP_MM_ECOM] && mm[CAP_MM_PWM] && mm[CAP_MM_TOG]) begin
         op = CAP_OP_FREQ;
      end else if (mm[CAP_MM_ECOM] && mm[CAP_MM_PWM]) begin
         op = mm[CAP_MM_WIDE] ? CAP_OP_PWM16
                              : CAP_OP_PWM8;
      end else if (mm[CAP_MM_ECOM] && mm[CAP_MM_MAT]) begin
         op = mm[CAP_MM_TOG] ? CAP_OP_HSO
                             : CAP_OP_SWT;
      end
      return op;
   endfunction

   // True when a write hits the given address.
   function automatic logic wr_hit(input cap_sfr_req_t rq,
                                   input logic [7:0]   a);
      return rq.wr && (rq.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State.

   logic [15:0] cnt_r;                  // Running counter.
   logic [15:0] cnt_nxt;                // Next counter value.
   logic        ovf_r;                  // Overflow flag.
   logic        run_r;                  // Run control.
   logic [5:0]  flag_r;                 // Module event flags.
   logic [5:0]  flag_nxt;               // Next module event flags.
   logic [7:0]  mode_r;                 // Array mode register.
   logic [7:0]  mm_r   [CAP_NMOD];      // Module mode registers.
   logic [7:0]  mm_nxt [CAP_NMOD];      // Next module mode registers.
   logic [7:0]  cpl_r  [CAP_NMOD];      // Compare low bytes.
   logic [7:0]  cpl_nxt[CAP_NMOD];      // Next compare low bytes.
   logic [7:0]  cph_r  [CAP_NMOD];      // Compare high bytes.
   logic [5:0]  pin_nxt;                // Next module outputs.
   logic [5:0]  set_ev;                 // Module events this cycle.
   logic [7:0]  snap_r;                 // High byte caught on low read.
   logic [7:0]  rd_val;                 // Read data before the register.
   logic [3:0]  div12_r;                // Divide by twelve counter.
   logic [1:0]  div4_r;                 // Divide by four counter.
   logic [2:0]  osc8_r;                 // Oscillator edge counter.
   logic [2:0]  eci_s_r;                // Count input synchroniser.
   logic        eci_lvl_r;              // Filtered count input level.
   logic [2:0]  osc_s_r;                // Oscillator synchroniser.
   logic        osc_lvl_r;              // Filtered oscillator level.

   ////////////////////////////////////////////////////////////////////////
   // Timebase selection.

   // Agreement of second and third stages qualifies a change.
   wire eci_agree = (eci_s_r[1] == eci_s_r[2]);
   wire osc_agree = (osc_s_r[1] == osc_s_r[2]);
   // Falling edge on the count input, held two clocks by the source.
   wire eci_fall  = eci_agree && !eci_s_r[2] && eci_lvl_r;
   wire osc_rise  = osc_agree && osc_s_r[2] && !osc_lvl_r;
   wire [2:0] tb_sel = mode_r[CAP_MODE_TB_HI:CAP_MODE_TB_LO];

   // Pulse picked by the timebase select; reserved codes never count.
   wire tb_pulse =
      (tb_sel == CAP_TB_DIV12) ? (div12_r == CAP_DIV12_LAST) :
      (tb_sel == CAP_TB_DIV4)  ? (div4_r == CAP_DIV4_LAST)   :
      (tb_sel == CAP_TB_T0OVF) ? timer0_ovf                  :
      (tb_sel == CAP_TB_EXTIN) ? eci_fall                    :
      (tb_sel == CAP_TB_SYS)   ? 1'b1                        :
      (tb_sel == CAP_TB_OSC8)  ? (osc_rise &&
                                  osc8_r == CAP_OSC8_LAST)  : 1'b0;

   // Counting is gated by run control and idle suspend.
   wire suspend = mode_r[CAP_MODE_IDLE] && cpu_idle;
   wire tick    = tb_pulse && run_r && !suspend;
   wire [15:0] cnt_inc  = cnt_r + 16'h0001;
   wire        full_ovf = tick && (cnt_r == CAP_CNT_TOP);
   wire        lo_wrap  = tick && (cnt_inc[7:0] == CAP_LO_ZERO);

   // Register write strobes.
   wire wr_ctrl = wr_hit(sfr_req, CAP_ADDR_CTRL);
   wire wr_mode = wr_hit(sfr_req, CAP_ADDR_MODE);
   wire wr_clo  = wr_hit(sfr_req, CAP_ADDR_CNT_LO);
   wire wr_chi  = wr_hit(sfr_req, CAP_ADDR_CNT_HI);

   ////////////////////////////////////////////////////////////////////////
   // Dividers and input synchronisers.

   // Free running dividers and filtered input levels.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div12_r   <= 4'h0;
         div4_r    <= 2'h0;
         osc8_r    <= 3'h0;
         eci_s_r   <= 3'h7;
         eci_lvl_r <= 1'b1;
         osc_s_r   <= 3'h0;
         osc_lvl_r <= 1'b0;
      end else begin
         div12_r <= (div12_r == CAP_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
         div4_r  <= div4_r + 2'h1;
         eci_s_r <= {eci_s_r[1:0], external_count_input};
         osc_s_r <= {osc_s_r[1:0], ext_osc_in};
         // Only an agreed level is taken as the new level.
         if (eci_agree) begin
            eci_lvl_r <= eci_s_r[2];
         end
         if (osc_agree) begin
            osc_lvl_r <= osc_s_r[2];
         end
         // Oscillator edges are counted in eights.
         if (osc_rise) begin
            osc8_r <= osc8_r + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Module behaviour.

   // Per-module compare, toggle and pulse width logic.
   always_comb begin
      cnt_nxt = tick ? cnt_inc : cnt_r;
      if (wr_clo) begin
         cnt_nxt[7:0] = sfr_req.wdata;
      end
      if (wr_chi) begin
         cnt_nxt[15:8] = sfr_req.wdata;
      end
      pin_nxt = module_io_pin;
      set_ev  = 6'h00;
      for (int i = 0; i < CAP_NMOD; i++) begin
         logic    m16;
         logic    m8;
         cap_op_t op;
         m16        = tick && (cnt_inc == {cph_r[i], cpl_r[i]});
         m8         = tick && (cnt_inc[7:0] == cpl_r[i]);
         op         = op_of(mm_r[i]);
         cpl_nxt[i] = cpl_r[i];
         mm_nxt[i]  = mm_r[i];
         // A full match with match enabled raises the event flag.
         if (mm_r[i][CAP_MM_ECOM] && mm_r[i][CAP_MM_MAT] && m16) begin
            set_ev[i] = 1'b1;
         end
         case (op)
            CAP_OP_HSO: begin
               if (m16) begin
                  pin_nxt[i] = !module_io_pin[i];
               end
            end
            CAP_OP_FREQ: begin
               // Next match lies the high byte further on; zero is 256.
               if (m8) begin
                  pin_nxt[i] = !module_io_pin[i];
                  cpl_nxt[i] = cpl_r[i] + cph_r[i];
               end
            end
            CAP_OP_PWM8: begin
               if (lo_wrap) begin
                  pin_nxt[i] = 1'b0;
                  cpl_nxt[i] = cph_r[i];
               end
               // A match on the same clock as the wrap wins.
               if (m8) begin
                  pin_nxt[i] = 1'b1;
               end
            end
            CAP_OP_PWM16: begin
               if (full_ovf) begin
                  pin_nxt[i] = 1'b0;
               end
               if (m16) begin
                  pin_nxt[i] = 1'b1;
               end
            end
            default: begin
            end
         endcase
         // Software writes to a module take priority over hardware.
         if (wr_hit(sfr_req, CAP_ADDR_MMODE0 + 8'(i))) begin
            mm_nxt[i] = sfr_req.wdata;
         end
         if (wr_hit(sfr_req, CAP_ADDR_CPL[i])) begin
            cpl_nxt[i]            = sfr_req.wdata;
            mm_nxt[i][CAP_MM_ECOM] = 1'b0;
         end
         if (wr_hit(sfr_req, CAP_ADDR_CPH[i])) begin
            mm_nxt[i][CAP_MM_ECOM] = 1'b1;
         end
      end
      // A hardware set wins over a software clear in the same clock.
      flag_nxt = (wr_ctrl ? sfr_req.wdata[5:0] : flag_r) | set_ev;
   end

   // Module registers and outputs.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flag_r        <= 6'h00;
         module_io_pin <= 6'h00;
         for (int i = 0; i < CAP_NMOD; i++) begin
            mm_r[i]  <= CAP_RST_BYTE;
            cpl_r[i] <= CAP_RST_BYTE;
            cph_r[i] <= CAP_RST_BYTE;
         end
      end else begin
         flag_r        <= flag_nxt;
         module_io_pin <= pin_nxt;
         for (int i = 0; i < CAP_NMOD; i++) begin
            mm_r[i]  <= mm_nxt[i];
            cpl_r[i] <= cpl_nxt[i];
            if (wr_hit(sfr_req, CAP_ADDR_CPH[i])) begin
               cph_r[i] <= sfr_req.wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array control, counter and interrupt.

   // Counter, run bit, overflow flag and the combined request.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_r   <= CAP_RST_CNT;
         run_r   <= 1'b0;
         ovf_r   <= 1'b0;
         mode_r  <= CAP_RST_BYTE;
         irq_req <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (wr_ctrl) begin
            run_r <= sfr_req.wdata[CAP_CTRL_RUN];
         end
         // Overflow set wins over a clear in the same clock.
         ovf_r <= (wr_ctrl ? sfr_req.wdata[CAP_CTRL_OVF] : ovf_r)
                  | full_ovf;
         if (wr_mode) begin
            mode_r <= sfr_req.wdata & CAP_MODE_MASK;
         end
         irq_req <= (ovf_r && mode_r[CAP_MODE_OVFIE]) ||
                    |(flag_r & {mm_r[5][CAP_MM_IRQE], mm_r[4][CAP_MM_IRQE],
                                mm_r[3][CAP_MM_IRQE], mm_r[2][CAP_MM_IRQE],
                                mm_r[1][CAP_MM_IRQE],
                                mm_r[0][CAP_MM_IRQE]});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads.

   // Read data selection by address.
   always_comb begin
      rd_val = CAP_RST_BYTE;
      if (sfr_req.addr == CAP_ADDR_CTRL) begin
         rd_val = {ovf_r, run_r, flag_r};
      end else if (sfr_req.addr == CAP_ADDR_MODE) begin
         rd_val = mode_r;
      end else if (sfr_req.addr == CAP_ADDR_CNT_LO) begin
         rd_val = cnt_r[7:0];
      end else if (sfr_req.addr == CAP_ADDR_CNT_HI) begin
         rd_val = snap_r;
      end else begin
         for (int i = 0; i < CAP_NMOD; i++) begin
            if (sfr_req.addr == CAP_ADDR_MMODE0 + 8'(i)) begin
               rd_val = mm_r[i];
            end
            if (sfr_req.addr == CAP_ADDR_CPL[i]) begin
               rd_val = cpl_r[i];
            end
            if (sfr_req.addr == CAP_ADDR_CPH[i]) begin
               rd_val = cph_r[i];
            end
         end
      end
   end

   // Read data register; a low byte read catches the high byte.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sfr_rdata <= CAP_RST_BYTE;
         snap_r    <= CAP_RST_BYTE;
      end else if (sfr_req.rd) begin
         sfr_rdata <= rd_val;
         if (sfr_req.addr == CAP_ADDR_CNT_LO) begin
            snap_r <= cnt_r[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Each mode is watched on the module that the bench runs in it.
   wire m1_hso  = (op_of(mm_r[1]) == CAP_OP_HSO);
   wire m5_p16  = (op_of(mm_r[5]) == CAP_OP_PWM16);
   wire m3_frq  = (op_of(mm_r[3]) == CAP_OP_FREQ);
   wire m0_hit  = tick && (cnt_inc == {cph_r[0], cpl_r[0]});
   wire m1_hit  = tick && (cnt_inc == {cph_r[1], cpl_r[1]});
   wire m5_hit  = tick && (cnt_inc == {cph_r[5], cpl_r[5]});
   wire m3_hit8 = tick && (cnt_inc[7:0] == cpl_r[3]);
   wire m1_wr   = sfr_req.wr && (sfr_req.addr == CAP_ADDR_CPL[1] ||
                  sfr_req.addr == CAP_ADDR_CPH[1] ||
                  sfr_req.addr == CAP_ADDR_MMODE0 + 8'h01);
   wire m3_wr   = sfr_req.wr && (sfr_req.addr == CAP_ADDR_CPL[3] ||
                  sfr_req.addr == CAP_ADDR_CPH[3] ||
                  sfr_req.addr == CAP_ADDR_MMODE0 + 8'h03);

   a_timer_flag_set: assert property (
      mm_r[0][CAP_MM_ECOM] && mm_r[0][CAP_MM_MAT] && m0_hit |=> flag_r[0])
      else $error("Module flag missed a full match.");
   a_flag_sticky: assert property (
      flag_r[0] && !wr_ctrl |=> flag_r[0])
      else $error("Module flag dropped without a write.");
   a_low_wr_clears: assert property (
      wr_hit(sfr_req, CAP_ADDR_CPL[1]) |=> !mm_r[1][CAP_MM_ECOM])
      else $error("Compare low write left compare enabled.");
   a_high_wr_sets: assert property (
      wr_hit(sfr_req, CAP_ADDR_CPH[1]) |=> mm_r[1][CAP_MM_ECOM])
      else $error("Compare high write left compare disabled.");
   a_hso_toggle: assert property (
      m1_hso && m1_hit && !m1_wr
      |=> module_io_pin[1] != $past(module_io_pin[1]))
      else $error("High speed output did not toggle.");
   a_freq_step: assert property (
      m3_frq && m3_hit8 && !m3_wr
      |=> cpl_r[3] == 8'($past(cpl_r[3]) + $past(cph_r[3])))
      else $error("Frequency step not added.");
   a_pwm16_low: assert property (
      m5_p16 && full_ovf && !m5_hit |=> !module_io_pin[5])
      else $error("Wide pulse not low after overflow.");
   a_ovf_flag: assert property (
      full_ovf |=> ovf_r ##1 (ovf_r || $past(wr_ctrl)))
      else $error("Overflow flag not set or not held.");
   a_run_hold: assert property (
      !run_r && !wr_clo && !wr_chi |=> $stable(cnt_r))
      else $error("Counter moved while stopped.");
   a_mode_unused: assert property (
      sfr_req.rd && sfr_req.addr == CAP_ADDR_MODE |=> sfr_rdata[6:4] == 3'h0)
      else $error("Unused mode bits read nonzero.");
   a_irq_merge: assert property (
      ovf_r && mode_r[CAP_MODE_OVFIE] |=> irq_req)
      else $error("Enabled overflow gave no request.");

   c_hso_toggle: cover property (m1_hso && m1_hit);
   c_pwm8_cycle: cover property (op_of(mm_r[4]) == CAP_OP_PWM8 && lo_wrap);
   c_freq_match: cover property (m3_frq && m3_hit8);
   c_overflow:   cover property (full_ovf);

endmodule

// ---- cap_pins_model.sv ----
// Model of the pins around the counter array: count input, oscillator, timer 0.
`timescale 1ns/1ps
module cap_pins_model (
   // Clock.
   input  wire logic ref_clk,
   // Pins driven towards the counter array.
   output logic      external_count_input,
   output logic      ext_osc_in,
   output logic      timer0_ovf
);
   // Free running phase of the model, stepped on the falling edge.
   logic [3:0] ph_r;

   // All pins start at a defined level.
   initial begin
      ph_r = 4'h0;
      external_count_input = 1'b1;
      ext_osc_in = 1'b0;
      timer0_ovf = 1'b0;
   end

   // The oscillator is slower than the clock and unrelated in phase.
   // Each level spans over two clocks so the input filter can see it.
   always #71 ext_osc_in = ~ext_osc_in;

   // Count input holds each level four clocks, a falling edge every eight.
   always @(negedge ref_clk) begin
      ph_r <= ph_r + 4'h1;
      external_count_input <= ~ph_r[2];
      timer0_ovf <= (ph_r[2:0] == 3'h7);
   end
endmodule

// ---- tb_counter_array_compare_pwm.sv ----
// Self-checking bench of the counter array compare and pulse width modes.
`timescale 1ns/1ps
module tb_counter_array_compare_pwm;
   import cap_pkg::*;
   logic         ref_clk = 1'b0;   // System clock.
   logic         reset;            // Synchronous reset.
   cap_sfr_req_t sfr_req;          // Register request bundle.
   logic [7:0]   sfr_rdata;        // Read data.
   logic         cpu_idle;         // Processor idle level.
   logic         timer0_ovf;       // From the pin model.
   logic         external_count_input;
   logic         ext_osc_in;
   logic [5:0]   module_io_pin;    // Module outputs.
   logic         irq_req;          // Combined request.
   int           err_count = 0;
   int           cmp_count = 0;
   int           cyc_count = 0;
   int           seed = 32'h8156;
   int           v;
   int           d1;
   int           d2;
   logic [7:0]   rd_v;
   logic [7:0]   h;
   // Timebase table: mode value, idle level and expected ticks in 240 clocks.
   logic [7:0]   tb_mode [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08,
                                 8'h0A, 8'h0C, 8'h88, 8'h08};
   int           tb_exp [9]  = '{20, 60, 30, 30, 240, 5, 0, 0, 240};
   logic [8:0]   tb_idl      = 9'h180;

   always #12.5 ref_clk = ~ref_clk;

   cap_counter_array i_cap_counter_array (
      .ref_clk(ref_clk), .reset(reset), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf),
      .external_count_input(external_count_input), .ext_osc_in(ext_osc_in),
      .module_io_pin(module_io_pin), .irq_req(irq_req));
   cap_pins_model i_cap_pins_model (
      .ref_clk(ref_clk), .external_count_input(external_count_input),
      .ext_osc_in(ext_osc_in), .timer0_ovf(timer0_ovf));

   ////////////////////////////////////////////////////////////////////////
   // Bus tasks hold each strobe for one full clock.
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge ref_clk);
      sfr_req.wr = 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a);
      @(negedge ref_clk);
      sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge ref_clk);
      sfr_req.rd = 1'b0;
      rd_v = sfr_rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                         input string what);
      sfr_rd(a);
      chk_byte(rd_v, e, what);
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] e,
                           input string what);
      cmp_count++;
      if (got !== e) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, e);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi,
                          input string what);
      cmp_count++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("[ERR] %0t %s got %0d exp %0d..%0d", $time, what, got,
                  lo, hi);
      end
   endtask
   // Counts the clocks in which one output is high.
   task automatic count_high(input int idx, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(negedge ref_clk);
         if (module_io_pin[idx] === 1'b1) c++;
      end
   endtask
   // Records three changes of one output and returns the two gaps.
   task automatic edges(input int idx, output int g1, output int g2);
      int   t[$];
      logic last;
      last = module_io_pin[idx];
      g1 = -1;
      g2 = -1;
      for (int i = 0; i < 700 && t.size() < 3; i++) begin
         @(negedge ref_clk);
         if (module_io_pin[idx] !== last) t.push_back(i);
         last = module_io_pin[idx];
      end
      if (t.size() == 3) begin
         g1 = t[1] - t[0];
         g2 = t[2] - t[1];
      end
   endtask
   task automatic tally_and_finish();
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A hang is cut short after far more clocks than the tests need.
   always @(posedge ref_clk) begin
      cyc_count++;
      if (cyc_count == 12000) begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      sfr_req = '0;
      cpu_idle = 1'b0;
      reset = 1'b1;
      repeat (20) @(negedge ref_clk);
      reset = 1'b0;
      rd_chk(CAP_ADDR_CTRL, 8'h00, "ctrl reset");
      rd_chk(CAP_ADDR_MODE, 8'h00, "mode reset");
      rd_chk(8'hC0, 8'h00, "unmapped read");
      sfr_wr(CAP_ADDR_MODE, 8'hFF);
      rd_chk(CAP_ADDR_MODE, 8'h8F, "mode unused bits");
      $display("test registers done");
      // Timer on module 0, high-speed output on module 1.
      sfr_wr(CAP_ADDR_MODE, 8'h08);
      sfr_wr(CAP_ADDR_MMODE0, 8'h49);
      sfr_wr(CAP_ADDR_CPL[0], 8'h30);
      rd_chk(CAP_ADDR_MMODE0, 8'h09, "low write");
      sfr_wr(CAP_ADDR_CPH[0], 8'h00);
      rd_chk(CAP_ADDR_MMODE0, 8'h49, "high write");
      sfr_wr(CAP_ADDR_MMODE0 + 8'h01, 8'h4C);
      sfr_wr(CAP_ADDR_CPL[1], 8'h34);
      sfr_wr(CAP_ADDR_CPH[1], 8'h00);
      sfr_wr(CAP_ADDR_CTRL, 8'h40);
      repeat (20) @(negedge ref_clk);
      rd_chk(CAP_ADDR_CTRL, 8'h40, "before match");
      chk_byte({2'b00, module_io_pin}, 8'h00, "pin before match");
      repeat (60) @(negedge ref_clk);
      rd_chk(CAP_ADDR_CTRL, 8'h43, "after match");
      chk_byte({2'b00, module_io_pin}, 8'h02, "pin toggled");
      chk_byte({7'h00, irq_req}, 8'h01, "flag request");
      repeat (30) @(negedge ref_clk);
      rd_chk(CAP_ADDR_CTRL, 8'h43, "flags kept");
      sfr_wr(CAP_ADDR_CTRL, 8'h03);
      rd_chk(CAP_ADDR_CNT_LO, 8'h76, "counter snap");
      v = rd_v;
      repeat (10) @(negedge ref_clk);
      rd_chk(CAP_ADDR_CNT_LO, 8'(v), "counter held");
      sfr_wr(CAP_ADDR_MMODE0, 8'h48);
      repeat (2) @(negedge ref_clk);
      chk_byte({7'h00, irq_req}, 8'h00, "flag masked");
      sfr_wr(CAP_ADDR_CTRL, 8'h00);
      sfr_wr(CAP_ADDR_MMODE0, 8'h00);
      sfr_wr(CAP_ADDR_MMODE0 + 8'h01, 8'h00);
      $display("test timer and toggle done");
      // Overflow flag with its enable off, then on.
      sfr_wr(CAP_ADDR_CNT_LO, 8'hF0);
      sfr_wr(CAP_ADDR_CNT_HI, 8'hFF);
      sfr_wr(CAP_ADDR_CTRL, 8'h40);
      repeat (30) @(negedge ref_clk);
      rd_chk(CAP_ADDR_CTRL, 8'hC0, "overflow flag");
      chk_byte({7'h00, irq_req}, 8'h00, "overflow masked");
      sfr_wr(CAP_ADDR_MODE, 8'h09);
      repeat (2) @(negedge ref_clk);
      chk_byte({7'h00, irq_req}, 8'h01, "overflow request");
      sfr_wr(CAP_ADDR_CTRL, 8'h00);
      repeat (2) @(negedge ref_clk);
      chk_byte({7'h00, irq_req}, 8'h00, "flags cleared");
      $display("test overflow done");
      // Frequency output on module 3, 8-bit PWM on module 4.
      h = 8'(($unsigned($random(seed)) % 8) + 2);
      sfr_wr(CAP_ADDR_CPL[3], 8'h00);
      sfr_wr(CAP_ADDR_CPH[3], h);
      sfr_wr(CAP_ADDR_MMODE0 + 8'h03, 8'h46);
      sfr_wr(CAP_ADDR_CTRL, 8'h40);
      edges(3, d1, d2);
      chk_cnt(d1, h, h, "half period one");
      chk_cnt(d2, h, h, "half period two");
      h = 8'(($unsigned($random(seed)) % 255) + 1);
      sfr_wr(CAP_ADDR_CPL[4], h);
      sfr_wr(CAP_ADDR_CPH[4], h);
      sfr_wr(CAP_ADDR_MMODE0 + 8'h04, 8'h42);
      repeat (300) @(negedge ref_clk);
      count_high(4, 256, v);
      chk_cnt(v, 256 - h, 256 - h, "pwm8 high time");
      $display("test frequency and pwm8 done");
      // 16-bit PWM across one overflow.
      sfr_wr(CAP_ADDR_CTRL, 8'h00);
      sfr_wr(CAP_ADDR_CNT_LO, 8'h00);
      sfr_wr(CAP_ADDR_CNT_HI, 8'hFF);
      sfr_wr(CAP_ADDR_CPL[5], 8'h80);
      sfr_wr(CAP_ADDR_CPH[5], 8'hFF);
      sfr_wr(CAP_ADDR_MMODE0 + 8'h05, 8'hCB);
      sfr_wr(CAP_ADDR_CTRL, 8'h40);
      count_high(5, 256, v);
      chk_cnt(v, 128, 128, "pwm16 high time");
      $display("test pwm16 done");
      // Timebase codes 0 to 6, then idle suspend on and off.
      for (int i = 0; i < 9; i++) begin
         sfr_wr(CAP_ADDR_CTRL, 8'h00);
         sfr_wr(CAP_ADDR_CNT_LO, 8'h00);
         sfr_wr(CAP_ADDR_CNT_HI, 8'h00);
         sfr_wr(CAP_ADDR_MODE, tb_mode[i]);
         cpu_idle = tb_idl[i];
         sfr_wr(CAP_ADDR_CTRL, 8'h40);
         repeat (239) @(negedge ref_clk);
         sfr_wr(CAP_ADDR_CTRL, 8'h00);
         sfr_rd(CAP_ADDR_CNT_LO);
         v = rd_v;
         chk_cnt(v, tb_exp[i] - 3, tb_exp[i] + 3, "timebase");
         rd_chk(CAP_ADDR_CNT_HI, 8'h00, "snapshot high");
      end
      cpu_idle = 1'b0;
      $display("test timebase done");
      tally_and_finish();
   end
endmodule
